/* File: hw/bcs_snoop.sv */
// second-level cache coherence snoop with duplicate tag stores and address holders
`timescale 1ns/1ps
module bcs_snoop #(
    parameter int INIT_LINES = bcs_pkg::INIT_LINES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bcs_pkg::bcs_snoop_t snoop,
    output bcs_pkg::bcs_resp_t resp,
    output bcs_pkg::bcs_pinv_t pinv_snoop,
    output bcs_pkg::bcs_pinv_t pinv_fill,
    input wire bcs_pkg::bcs_pfill_t pfill_proc,
    input wire bcs_pkg::bcs_pfill_t pfill_bus,
    input wire bcs_pkg::bcs_bfill_t bfill,
    input wire bcs_pkg::bcs_bstat_t bstat,
    input wire bcs_pkg::bcs_probe_t probe,
    output bcs_pkg::bcs_probe_res_t probe_res,
    input wire logic rei_exec,
    output logic icache_flush,
    input wire logic refill_posted,
    input wire logic victim_done,
    output logic victim_wb_req,
    output logic miss_stall
);
    // duplicate tag stores and dirty shadow
    logic [bcs_pkg::BMAP_W-1:0] bmap_q [0:(1<<bcs_pkg::BIDX_W)-1];
    logic bdirty_q [0:(1<<bcs_pkg::BIDX_W)-1];
    logic [bcs_pkg::PMAP_W-1:0] pmap_q [0:bcs_pkg::PSETS-1][0:bcs_pkg::PDEPTH-1];

    bcs_pkg::bcs_state_t state_q;
    logic [bcs_pkg::BIDX_W:0] init_cnt_q;
    logic [31:0] ctrl_q, lock_q, vict_q, wpend_q;
    logic perr_q;
    logic [bcs_pkg::CNT_W-1:0] upd_cnt_q, inv_cnt_q;
    bcs_pkg::bcs_snoop_t s1_q;

    logic [bcs_pkg::BIDX_W-1:0] bidx;
    logic [bcs_pkg::BMAP_W-1:0] bent;
    logic bhit, bdirty, phit, run, rd, wr;
    logic lock_m, vict_m, wpend_m;
    logic do_update, do_binval, do_vdrop;
    logic bfill_old_v;
    logic apb_wr, apb_setup, mapped;

    // even parity over a field
    function automatic logic par(input logic [bcs_pkg::PADDR_W:0] v);
        par = ^v;
    endfunction

    // entry is valid and belongs to this second-level line
    function automatic logic pmap_covers(input logic [bcs_pkg::PMAP_W-1:0] e, input logic [bcs_pkg::BIDX_W-1:0] idx);
        pmap_covers = e[1] && e[bcs_pkg::PMAP_W-1:2] == idx[bcs_pkg::BIDX_W-1:6];
    endfunction

    // any primary backmap entry covering this second-level line
    function automatic logic pmap_line_hit(input logic [bcs_pkg::BIDX_W-1:0] idx);
        logic [bcs_pkg::PMAP_W-1:0] e;
        pmap_line_hit = 1'b0;
        for (int s = 0; s < bcs_pkg::PSETS; s++)
        begin
            for (int h = 0; h < 2; h++)
            begin
                e = pmap_q[s][{idx[5:0], h[0]}];
                if (pmap_covers(e, idx))
                    pmap_line_hit = 1'b1;
            end
        end
    endfunction

    // entry layout: address field, valid, parity
    function automatic logic [bcs_pkg::PMAP_W-1:0] pmap_ent(input logic [bcs_pkg::ADDR_W-1:0] a);
        pmap_ent = {a[21:12], 1'b1, par({a[21:12], 1'b1})};
    endfunction

    assign run = (state_q == bcs_pkg::BCS_RUN) && ctrl_q[bcs_pkg::CTRL_EN_BIT];

    // init sweep: backmaps hold garbage at power-up, so snoops wait until it ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= bcs_pkg::BCS_INIT;
            init_cnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                bcs_pkg::BCS_INIT:
                begin
                    init_cnt_q <= init_cnt_q + 1'b1;
                    if (init_cnt_q == (bcs_pkg::BIDX_W+1)'(INIT_LINES - 1))
                        state_q <= bcs_pkg::BCS_RUN;
                end
                bcs_pkg::BCS_RUN:
                    init_cnt_q <= init_cnt_q;
                default:
                    state_q <= bcs_pkg::BCS_INIT;
            endcase
        end
    end

    // capture the bus command/address cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s1_q <= '0;
        else
            s1_q <= snoop;
    end

    // lookup of both backmaps on the captured cycle
    always_comb
    begin
        rd = s1_q.valid && !s1_q.write && run;
        wr = s1_q.valid && s1_q.write && run;
        bidx = s1_q.addr[21:6];
        bent = bmap_q[bidx];
        bhit = bent[1] && bent[bcs_pkg::BMAP_W-1:2] == s1_q.addr[33:22];
        bdirty = bdirty_q[bidx];
        phit = pmap_line_hit(bidx);
        lock_m = lock_q[bcs_pkg::HOLD_VALID_BIT] && lock_q[27:0] == s1_q.addr[33:6];
        vict_m = vict_q[bcs_pkg::HOLD_VALID_BIT] && vict_q[27:0] == s1_q.addr[33:6];
        wpend_m = wpend_q[bcs_pkg::HOLD_VALID_BIT] && wpend_q[27:0] == s1_q.addr[33:6];
        // the primary map only matters once the write hits the second-level map
        do_update = wr && ((bhit && phit) || wpend_m);
        do_binval = wr && bhit && !phit && !wpend_m;
        do_vdrop = wr && vict_m;
    end

    // snoop response, registered one cycle after capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            resp <= '0;
        else
        begin
            resp.valid <= s1_q.valid && run;
            resp.shared <= (rd && (bhit || lock_m || vict_m || wpend_m)) || (wr && (bhit || vict_m || wpend_m));
            resp.dirty <= (rd && bhit && bdirty) || vict_m && (rd || wr);
            resp.supply_cache <= rd && bhit && bdirty && !vict_m;
            resp.supply_victim <= rd && vict_m;
            resp.take_update <= do_update;
            resp.bc_inval <= do_binval;
            resp.vict_withdraw <= do_vdrop;
        end
    end

    // primary cache invalidates from updates and refills
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pinv_snoop <= '0;
            pinv_fill <= '0;
        end
        else
        begin
            pinv_snoop.valid <= do_update && phit;
            pinv_snoop.idx <= bidx;
            pinv_fill.valid <= bfill.valid && bfill_old_v && pmap_line_hit(bfill.addr[21:6]);
            pinv_fill.idx <= bfill.addr[21:6];
        end
    end

    assign bfill_old_v = bmap_q[bfill.addr[21:6]][1];

    // second-level backmap: sweep, snoop invalidate, then refill tag write
    always_ff @(posedge pclk)
    begin
        if (state_q == bcs_pkg::BCS_INIT)
            bmap_q[init_cnt_q[bcs_pkg::BIDX_W-1:0]] <= '0;
        else
        begin
            if (do_binval)
                bmap_q[bidx] <= '0;
            if (bfill.valid)
                bmap_q[bfill.addr[21:6]] <= {bfill.addr[33:22], 1'b1, ^{bfill.addr[33:22], 1'b1}};
        end
    end

    // dirty shadow: a bus write that hits here or matches the pending holder leaves the line clean
    always_ff @(posedge pclk)
    begin
        if (state_q == bcs_pkg::BCS_INIT)
            bdirty_q[init_cnt_q[bcs_pkg::BIDX_W-1:0]] <= 1'b0;
        else
        begin
            if (wr && (bhit || wpend_m))
                bdirty_q[bidx] <= 1'b0;
            if (bfill.valid)
                bdirty_q[bfill.addr[21:6]] <= 1'b0;
            if (bstat.valid)
                bdirty_q[bstat.idx] <= bstat.dirty;
        end
    end

    // primary backmap: two 128-entry arrays of 12 bits
    generate
        for (genvar s = 0; s < bcs_pkg::PSETS; s++)
        begin : g_pset
            always_ff @(posedge pclk)
            begin
                if (state_q == bcs_pkg::BCS_INIT)
                    pmap_q[s][init_cnt_q[bcs_pkg::PIDX_W-1:0]] <= '0;
                else
                begin
                    // only entries of the dying line are dropped; other lines sharing the slot stay tracked
                    for (int h = 0; h < 2; h++)
                    begin
                        if (do_update && phit && pmap_covers(pmap_q[s][{bidx[5:0], h[0]}], bidx))
                            pmap_q[s][{bidx[5:0], h[0]}] <= '0;
                        if (bfill.valid && pmap_covers(pmap_q[s][{bfill.addr[11:6], h[0]}], bfill.addr[21:6]))
                            pmap_q[s][{bfill.addr[11:6], h[0]}] <= '0;
                    end
                    // processor loads on read hits, bus side on read misses
                    if (pfill_bus.valid && pfill_bus.set == s[0])
                        pmap_q[s][pfill_bus.addr[11:5]] <= pmap_ent(pfill_bus.addr);
                    if (pfill_proc.valid && pfill_proc.set == s[0])
                        pmap_q[s][pfill_proc.addr[11:5]] <= pmap_ent(pfill_proc.addr);
                end
            end
        end
    endgenerate

    // apb decode; zero wait states
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign mapped = paddr == bcs_pkg::CTRL_OFF || paddr == bcs_pkg::LOCK_OFF || paddr == bcs_pkg::VICT_OFF
        || paddr == bcs_pkg::WPEND_OFF || paddr == bcs_pkg::STAT_OFF || paddr == bcs_pkg::CNT_OFF;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // control and pending-write holder
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= bcs_pkg::CTRL_RST;
            wpend_q <= bcs_pkg::HOLD_RST;
        end
        else if (apb_wr && paddr == bcs_pkg::CTRL_OFF)
            ctrl_q <= pwdata & 32'h0000_0001;
        else if (apb_wr && paddr == bcs_pkg::WPEND_OFF)
            wpend_q <= {pwdata[31], 3'h0, pwdata[27:0]};
    end

    // lock holder; a software load wins over a snoop clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lock_q <= bcs_pkg::HOLD_RST;
        else if (apb_wr && paddr == bcs_pkg::LOCK_OFF)
            lock_q <= {pwdata[31], 3'h0, pwdata[27:0]};
        else if (wr && lock_m)
            lock_q[bcs_pkg::HOLD_VALID_BIT] <= 1'b0;
    end

    // victim holder: refill posting gates the write-back
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vict_q <= bcs_pkg::HOLD_RST;
        else if (apb_wr && paddr == bcs_pkg::VICT_OFF)
            vict_q <= {pwdata[31], 3'h0, pwdata[27:0]};
        else if (do_vdrop || victim_done)
            vict_q <= bcs_pkg::HOLD_RST;
        else if (refill_posted && vict_q[bcs_pkg::HOLD_VALID_BIT])
            vict_q[bcs_pkg::VICT_POSTED_BIT] <= 1'b1;
    end

    // write-back only after the refill went out; second miss held off
    always_comb
    begin
        victim_wb_req = vict_q[bcs_pkg::HOLD_VALID_BIT] && vict_q[bcs_pkg::VICT_POSTED_BIT];
        miss_stall = vict_q[bcs_pkg::HOLD_VALID_BIT];
    end

    // sticky parity error on looked-up second-level entries only; hardware set beats write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            perr_q <= 1'b0;
        else if (s1_q.valid && run && (^bent))
            perr_q <= 1'b1;
        else if (apb_wr && paddr == bcs_pkg::STAT_OFF && pwdata[bcs_pkg::STAT_PERR_BIT])
            perr_q <= 1'b0;
    end

    // update and invalidate counters, wrap silently
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            upd_cnt_q <= bcs_pkg::CNT_RST;
            inv_cnt_q <= bcs_pkg::CNT_RST;
        end
        else
        begin
            if (do_update)
                upd_cnt_q <= upd_cnt_q + 1'b1;
            if (do_binval)
                inv_cnt_q <= inv_cnt_q + 1'b1;
        end
    end

    // read data registered in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (apb_setup && !pwrite)
        begin
            unique case (paddr)
                bcs_pkg::CTRL_OFF: prdata <= ctrl_q;
                bcs_pkg::LOCK_OFF: prdata <= lock_q;
                bcs_pkg::VICT_OFF: prdata <= vict_q;
                bcs_pkg::WPEND_OFF: prdata <= wpend_q;
                bcs_pkg::STAT_OFF: prdata <= {29'h0, miss_stall, perr_q, state_q == bcs_pkg::BCS_RUN};
                bcs_pkg::CNT_OFF: prdata <= {upd_cnt_q, inv_cnt_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // processor tag probe outcome
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            probe_res <= '0;
        else
        begin
            probe_res.valid <= probe.valid;
            probe_res.hit <= probe.valid && probe.tag_match && probe.v && !(probe.write && probe.s);
            probe_res.broadcast <= probe.valid && probe.write && probe.tag_match && probe.v && probe.s;
        end
    end

    // virtually addressed instruction cache has no backmap, flush instead
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            icache_flush <= 1'b0;
        else
            icache_flush <= rei_exec;
    end
endmodule

/* File: common/bcs_pkg.sv */
// package for the second-level cache snoop block: constants and carrier types
// Functional notes
// - bus write leaves line clean everywhere, memory updated
// - write hitting primary cache: update line, invalidate primary
// - write missing primary, hitting second level: invalidate
// - compare bus address with lock, victim, pending holders
// - read matching victim: supply from victim buffer
// - write matching victim: drop victim, withdraw request
// - write matching pending holder: take update
// - read hitting dirty line: this module drives data
// - write to needed line is update, stays valid
// - write to unneeded line makes it invalid
// - both backmaps looked up every bus cycle
// - instruction cache flushed on return from exception
// - primary backmap: two 128 by 12-bit arrays
// - primary backmap written on read hits and misses
// - primary backmap consulted when write hits second map
// - invalidate primary lines when second-level line dies
// - write probe needs valid, not shared; read needs valid
// - write probe to shared line is broadcast
// - refill before victim write-back, one victim only
package bcs_pkg;
    localparam int ADDR_W = 34;
    localparam int BIDX_W = 16;
    localparam int BTAG_W = 12;
    localparam int LINE_W = 28;
    localparam int PIDX_W = 7;
    localparam int PSETS = 2;
    localparam int PDEPTH = 128;
    localparam int PADDR_W = 10;
    localparam int PMAP_W = 12;
    localparam int BMAP_W = 14;
    localparam int CNT_W = 16;
    localparam int INIT_LINES = 65536;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] LOCK_OFF = 8'h04;
    localparam logic [7:0] VICT_OFF = 8'h08;
    localparam logic [7:0] WPEND_OFF = 8'h0C;
    localparam logic [7:0] STAT_OFF = 8'h10;
    localparam logic [7:0] CNT_OFF = 8'h14;
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int HOLD_VALID_BIT = 31;
    localparam int VICT_POSTED_BIT = 30;
    localparam int STAT_INIT_BIT = 0;
    localparam int STAT_PERR_BIT = 1;
    localparam int STAT_STALL_BIT = 2;
    // values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] HOLD_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    typedef enum logic [1:0] {BCS_INIT = 2'b01, BCS_RUN = 2'b10} bcs_state_t;

    typedef struct packed {logic valid; logic write; logic [ADDR_W-1:0] addr;} bcs_snoop_t;
    typedef struct packed {
        logic valid;
        logic shared;
        logic dirty;
        logic supply_cache;
        logic supply_victim;
        logic take_update;
        logic bc_inval;
        logic vict_withdraw;
    } bcs_resp_t;
    typedef struct packed {logic valid; logic [BIDX_W-1:0] idx;} bcs_pinv_t;
    typedef struct packed {logic valid; logic set; logic [ADDR_W-1:0] addr;} bcs_pfill_t;
    typedef struct packed {logic valid; logic [ADDR_W-1:0] addr;} bcs_bfill_t;
    typedef struct packed {logic valid; logic [BIDX_W-1:0] idx; logic dirty;} bcs_bstat_t;
    typedef struct packed {logic valid; logic write; logic tag_match; logic v; logic s;} bcs_probe_t;
    typedef struct packed {logic valid; logic hit; logic broadcast;} bcs_probe_res_t;
endpackage

/* File: tb/bcs_snoop_props.sv */
// checker: snoop response timing and field relations at the block's ports
`timescale 1ns/1ps
module bcs_snoop_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire bcs_pkg::bcs_snoop_t snoop,
    input wire bcs_pkg::bcs_resp_t resp,
    input wire bcs_pkg::bcs_pinv_t pinv_snoop,
    input wire bcs_pkg::bcs_pinv_t pinv_fill,
    input wire bcs_pkg::bcs_bfill_t bfill,
    input wire bcs_pkg::bcs_probe_t probe,
    input wire bcs_pkg::bcs_probe_res_t probe_res,
    input wire logic rei_exec,
    input wire logic icache_flush
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // the command two edges back decides what a response may carry
    sequence wr_ago;
        $past(snoop.valid && snoop.write, 2);
    endsequence
    sequence rd_ago;
        $past(snoop.valid && !snoop.write, 2);
    endsequence
    resp_cause_a: assert property (resp.valid |-> $past(snoop.valid, 2))
        else $error("response without a snoop");
    victim_read_a: assert property (resp.supply_victim |-> resp.shared && resp.dirty ##0 rd_ago)
        else $error("victim supply wrong");
    victim_write_a: assert property (resp.vict_withdraw |-> resp.shared && resp.dirty ##0 wr_ago)
        else $error("victim withdraw wrong");
    update_only_a: assert property (resp.take_update |-> !resp.bc_inval ##0 wr_ago)
        else $error("update wrong");
    inval_write_a: assert property (resp.bc_inval |-> !resp.supply_cache ##0 wr_ago)
        else $error("invalidate wrong");
    dirty_supply_a: assert property (resp.supply_cache |-> resp.dirty ##0 rd_ago)
        else $error("cache supply wrong");
    pinv_update_a: assert property (pinv_snoop.valid |-> resp.take_update
        && pinv_snoop.idx == $past(snoop.addr[21:6], 2))
        else $error("primary invalidate wrong");
    rei_flush_a: assert property (rei_exec |=> icache_flush)
        else $error("no instruction cache flush");
    probe_hit_a: assert property (probe.valid |=> probe_res.valid
        && probe_res.hit == ($past(probe.tag_match && probe.v) && !$past(probe.write && probe.s)))
        else $error("probe hit wrong");
    probe_bcast_a: assert property (probe.valid |=>
        probe_res.broadcast == $past(probe.write && probe.tag_match && probe.v && probe.s))
        else $error("probe broadcast wrong");
    fill_pinv_a: assert property (pinv_fill.valid |-> $past(bfill.valid)
        && pinv_fill.idx == $past(bfill.addr[21:6]))
        else $error("fill invalidate wrong");
endmodule
bind bcs_snoop bcs_snoop_props u_props (.pclk(pclk), .presetn(presetn), .snoop(snoop), .resp(resp),
    .pinv_snoop(pinv_snoop), .pinv_fill(pinv_fill), .bfill(bfill), .probe(probe), .probe_res(probe_res),
    .rei_exec(rei_exec), .icache_flush(icache_flush));

/* File: tb/bcs_bus_node.sv */
// far-side bus node model: issues command/address cycles toward the snoop block
`timescale 1ns/1ps
module bcs_bus_node (
    input wire logic pclk,
    output bcs_pkg::bcs_snoop_t snoop
);
    initial snoop = '0;
    // one command a call; a released cycle shows the inverted address so stale values never look live
    task automatic cmd(input logic wr, input logic [33:0] a);
        @(posedge pclk);
        snoop <= {1'h1, wr, a};
        @(posedge pclk);
        snoop <= {1'h0, 1'h0, ~a};
    endtask
endmodule

/* File: tb/tb.sv */
// testbench: register access, bus snoops, probes and backmap fills
`timescale 1ns/1ps
module tb;
    localparam logic [33:0] A1 = {12'h001, 16'h0010, 6'h00};
    localparam logic [33:0] A2 = {12'h002, 16'h0011, 6'h00};
    localparam logic [33:0] A3 = {12'h003, 16'h0012, 6'h00};
    localparam logic [33:0] A4 = {12'h004, 16'h0013, 6'h00};
    localparam logic [33:0] A5 = {12'h005, 16'h0014, 6'h00};
    localparam logic [33:0] A6 = {12'h00A, 16'h0020, 6'h00};
    localparam logic [33:0] A7 = {12'h00B, 16'h0020, 6'h00};
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic rei_exec = 1'h0;
    logic refill_posted = 1'h0;
    logic victim_done = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [7:0] rsp;
    logic pready, pslverr, err, icache_flush, victim_wb_req, miss_stall;
    bcs_pkg::bcs_snoop_t snoop;
    bcs_pkg::bcs_resp_t resp;
    bcs_pkg::bcs_pinv_t pinv_snoop, pinv_fill, pv;
    bcs_pkg::bcs_pfill_t pfill_proc = '0;
    bcs_pkg::bcs_pfill_t pfill_bus = '0;
    bcs_pkg::bcs_bfill_t bfill = '0;
    bcs_pkg::bcs_bstat_t bstat = '0;
    bcs_pkg::bcs_probe_t probe = '0;
    bcs_pkg::bcs_probe_res_t probe_res;
    int failures = 0;
    int check_count = 0;

    // short sweep keeps the run brief; still covers the primary map
    bcs_snoop #(.INIT_LINES(256)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .snoop(snoop), .resp(resp), .pinv_snoop(pinv_snoop), .pinv_fill(pinv_fill), .pfill_proc(pfill_proc),
        .pfill_bus(pfill_bus), .bfill(bfill), .bstat(bstat), .probe(probe), .probe_res(probe_res),
        .rei_exec(rei_exec), .icache_flush(icache_flush), .refill_posted(refill_posted),
        .victim_done(victim_done), .victim_wb_req(victim_wb_req), .miss_stall(miss_stall));
    bcs_bus_node node (.pclk(pclk), .snoop(snoop));

    always #4 pclk = ~pclk;

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic timeout();
        failures++;
        finish_test();
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        repeat (16)
        begin
            @(posedge pclk);
            if (pready === 1'h1)
                break;
        end
        if (pready !== 1'h1)
            timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // response lands two edges after the command edge
    task automatic snp(input logic w, input logic [33:0] a, input logic [7:0] m, input logic [7:0] e);
        node.cmd(w, a);
        @(posedge pclk);
        #1;
        rsp = resp;
        pv = pinv_snoop;
        chk(32'(rsp & m), 32'(e));
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        snp(1'h0, A1, 8'h80, 8'h00);
        apb(1'h0, bcs_pkg::CTRL_OFF, 32'h0);
        chk(rd, bcs_pkg::CTRL_RST);
        apb(1'h0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        repeat (200)
        begin
            apb(1'h0, bcs_pkg::STAT_OFF, 32'h0);
            if (rd[0] === 1'h1)
                break;
        end
        if (rd[0] !== 1'h1)
            timeout();
        // second-level lines A1 (dirty) and A2, then a primary copy of A1
        @(posedge pclk);
        bfill <= {1'h1, A1};
        @(posedge pclk);
        bfill <= {1'h1, A2};
        bstat <= {1'h1, 16'h0010, 1'h1};
        @(posedge pclk);
        bfill <= '0;
        bstat <= '0;
        snp(1'h0, A1, 8'hFF, 8'hF0);
        @(posedge pclk);
        pfill_proc <= {1'h1, 1'h0, A1};
        @(posedge pclk);
        pfill_proc <= '0;
        snp(1'h1, A1, 8'h87, 8'h84);
        chk(32'(pv), 32'({1'h1, 16'h0010}));
        snp(1'h0, A1, 8'hFF, 8'hC0);
        snp(1'h1, A2, 8'h97, 8'h82);
        snp(1'h0, A2, 8'hFF, 8'h80);
        apb(1'h1, bcs_pkg::CTRL_OFF, 32'h0);
        snp(1'h0, A1, 8'h80, 8'h00);
        apb(1'h1, bcs_pkg::CTRL_OFF, 32'h1);
        // address holders: lock, pending write, victim
        apb(1'h1, bcs_pkg::LOCK_OFF, {4'h8, A3[33:6]});
        apb(1'h1, bcs_pkg::WPEND_OFF, {4'h8, A4[33:6]});
        apb(1'h1, bcs_pkg::VICT_OFF, {4'h8, A5[33:6]});
        snp(1'h0, A3, 8'hFF, 8'hC0);
        snp(1'h1, A3, 8'hA7, 8'h80);
        apb(1'h0, bcs_pkg::LOCK_OFF, 32'h0);
        chk(rd, {4'h0, A3[33:6]});
        snp(1'h0, A4, 8'hFF, 8'hC0);
        snp(1'h1, A4, 8'h87, 8'h84);
        chk(32'(victim_wb_req), 32'h0);
        chk(32'(miss_stall), 32'h1);
        @(posedge pclk);
        refill_posted <= 1'h1;
        @(posedge pclk);
        refill_posted <= 1'h0;
        #1;
        chk(32'(victim_wb_req), 32'h1);
        snp(1'h0, A5, 8'hFF, 8'hE8);
        snp(1'h1, A5, 8'hE1, 8'hE1);
        chk(32'(victim_wb_req), 32'h0);
        // a completed write-back frees the single victim slot
        apb(1'h1, bcs_pkg::VICT_OFF, {4'h8, A5[33:6]});
        @(posedge pclk);
        victim_done <= 1'h1;
        #1;
        chk(32'(miss_stall), 32'h1);
        @(posedge pclk);
        victim_done <= 1'h0;
        #1;
        chk(32'(miss_stall), 32'h0);
        // two updates (A1, A4) and one invalidate (A2) so far
        apb(1'h0, bcs_pkg::CNT_OFF, 32'h0);
        chk(rd, 32'h0002_0001);
        // refill displacing a line with a primary copy
        @(posedge pclk);
        bfill <= {1'h1, A6};
        @(posedge pclk);
        bfill <= '0;
        pfill_bus <= {1'h1, 1'h0, A6};
        @(posedge pclk);
        pfill_bus <= '0;
        bfill <= {1'h1, A7};
        @(posedge pclk);
        bfill <= '0;
        #1;
        chk(32'(pinv_fill), 32'({1'h1, 16'h0020}));
        // every probe combination: write, tag match, valid, shared
        for (int i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            probe <= {1'h1, 4'(i)};
            @(posedge pclk);
            probe <= '0;
            #1;
            chk(32'(probe_res), 32'({1'h1, i[2] & i[1] & ~(i[3] & i[0]), i[3] & i[2] & i[1] & i[0]}));
        end
        @(posedge pclk);
        rei_exec <= 1'h1;
        @(posedge pclk);
        rei_exec <= 1'h0;
        #1;
        chk(32'(icache_flush), 32'h1);
        finish_test();
    end
endmodule
